// ==== hw/dpr_cfg.svh ====
// constants of the dual-port ram port logic
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH
`define DPR_ADDR_W 17
`define DPR_LANES 8
`define DPR_LANE_W 9
`define DPR_DATA_W 72
`define DPR_DEPTH 131072
`define DPR_MBOX_P0 17'h1fffe
`define DPR_MBOX_P1 17'h1ffff
`define DPR_CLK_MHZ 250
`define DPR_SLOW_MHZ 100
`define DPR_LOCK_NS 64
`define DPR_LOCK_CYC ((`DPR_LOCK_NS * `DPR_CLK_MHZ + 999) / 1000)
`define DPR_CNT_W 8
`endif

// ==== hw/dpr_pkg.sv ====
// types and decode helpers of the dual-port ram port logic
`include "dpr_cfg.svh"
package dpr_pkg;
    typedef logic [`DPR_ADDR_W-1:0] dpr_addr_t;
    typedef logic [`DPR_DATA_W-1:0] dpr_data_t;
    typedef logic [`DPR_LANES-1:0] dpr_lanes_t;
    typedef enum logic [1:0] {
        DPR_DLL_OFF,
        DPR_DLL_LOCKING,
        DPR_DLL_LOCKED
    } dpr_dll_st_t;

    // mailbox address owned by a port
    function automatic dpr_addr_t dpr_mbox(input logic owner);
        dpr_mbox = owner ? `DPR_MBOX_P1 : `DPR_MBOX_P0;
    endfunction

    // widen lane enables to one bit per data bit
    function automatic dpr_data_t dpr_expand(input dpr_lanes_t lanes);
        dpr_expand = '0;
        for (int i = 0; i < `DPR_LANES; i++) begin
            dpr_expand[i*`DPR_LANE_W +: `DPR_LANE_W] = {`DPR_LANE_W{lanes[i]}};
        end
    endfunction
endpackage

// ==== hw/dpr_mem_if.sv ====
// request and read-data bundle between port logic and array
interface dpr_mem_if;
    import dpr_pkg::*;
    logic [1:0] en;
    logic [1:0] we;
    dpr_lanes_t be [2];
    dpr_addr_t addr [2];
    dpr_data_t wdata [2];
    dpr_data_t rdata [2];
    modport ctrl (output en, we, be, addr, wdata, input rdata);
    modport mem (input en, we, be, addr, wdata, output rdata);
endinterface

// ==== hw/dpr_mem.sv ====
// true dual-port array with byte lanes and registered read data
`include "dpr_cfg.svh"
module dpr_mem
    import dpr_pkg::*;
(
    // clocking
    input wire logic clk,
    input wire logic ce,
    // requests
    dpr_mem_if.mem bus
);
    dpr_data_t mem_q [`DPR_DEPTH];
    dpr_data_t rdata_q [2];

    // lane writes, port 1 last; reads return the whole word
    always_ff @(posedge clk) begin
        if (ce) begin
            for (int p = 0; p < 2; p++) begin
                for (int l = 0; l < `DPR_LANES; l++) begin
                    if (bus.en[p] && bus.we[p] && bus.be[p][l]) begin
                        mem_q[bus.addr[p]][l*`DPR_LANE_W +: `DPR_LANE_W] <=
                            bus.wdata[p][l*`DPR_LANE_W +: `DPR_LANE_W];
                    end
                end
                if (bus.en[p] && !bus.we[p]) begin
                    rdata_q[p] <= mem_q[bus.addr[p]];
                end
            end
        end
    end

    assign bus.rdata[0] = rdata_q[0];
    assign bus.rdata[1] = rdata_q[1];
endmodule

// ==== hw/dpr_top.sv ====
// per-port pin logic of a synchronous dual-port ram, index 0 left, 1 right
// Overview of operation
// RULE1 - write select low writes, high reads
// RULE2 - low-active chip select high deselects port
// RULE3 - high-active chip select low deselects port
// RULE4 - byte-lane enables gate reads and writes
// RULE5 - data pins drive only while output enable low
// RULE6 - busy asserted on port collision
// RULE7 - two top addresses are port mailboxes
// RULE8 - writing other port's mailbox pulls its flag low
// RULE9 - reading own mailbox releases own flag
// RULE10 - slow clock select disables port dll
// RULE11 - ready only once port can operate
// RULE12 - each port registers address, control, data
// RULE13 - hosts avoid same-location simultaneous writes
`include "dpr_cfg.svh"
module dpr_top
    import dpr_pkg::*;
(
    // clock, enable, reset
    input wire logic clk,
    input wire logic ce,
    input wire logic sys_rst,
    // address and control pins per port
    input wire logic [1:0][`DPR_ADDR_W-1:0] addr,
    input wire logic [1:0] write_select_n,
    input wire logic [1:0] chip_select_low_active_n,
    input wire logic [1:0] chip_select_high_active,
    input wire logic [1:0][`DPR_LANES-1:0] byte_lane_enable_n,
    input wire logic [1:0] output_enable_n,
    input wire logic [1:0] slow_clock_select,
    // data pins per port
    input wire logic [1:0][`DPR_DATA_W-1:0] dq_i,
    output logic [1:0][`DPR_DATA_W-1:0] dq_o,
    output logic [1:0][`DPR_DATA_W-1:0] dq_oe_n,
    // status pins per port
    output logic [1:0] busy,
    output logic [1:0] mailbox_flag_n,
    output logic [1:0] ready,
    output logic [1:0] dll_enable
);
    dpr_mem_if mbus();

    // pin synchronisers, first stage read only by second
    dpr_addr_t a_s1_q [2], a_s2_q [2];
    dpr_data_t d_s1_q [2], d_s2_q [2];
    dpr_lanes_t be_s1_q [2], be_s2_q [2];
    logic [1:0] wr_s1_q, wr_s2_q, csl_s1_q, csl_s2_q;
    logic [1:0] csh_s1_q, csh_s2_q, oe_s1_q, oe_s2_q;
    logic [1:0] slow_s1_q, slow_s2_q;

    // registered requests
    logic [1:0] req_en_q, req_en_d, req_we_q, req_we_d;
    dpr_lanes_t req_be_q [2], req_be_d [2];
    dpr_addr_t req_a_q [2], req_a_d [2];
    dpr_data_t req_wd_q [2], req_wd_d [2];

    // read lanes, mailbox, busy, dll state
    dpr_lanes_t rd_lane_q [2], rd_lane_d [2];
    logic [1:0] mbox_q, mbox_d, busy_q, busy_d;
    dpr_dll_st_t dll_q [2], dll_d [2];
    logic [`DPR_CNT_W-1:0] lock_q [2], lock_d [2];
    logic [1:0] dll_en_q, dll_en_d;
    logic collide;

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            // two-stage capture of every input pin of the port
            always_ff @(posedge clk) begin
                if (ce) begin
                    a_s1_q[p] <= addr[p];
                    a_s2_q[p] <= a_s1_q[p];
                    d_s1_q[p] <= dq_i[p];
                    d_s2_q[p] <= d_s1_q[p];
                    be_s1_q[p] <= byte_lane_enable_n[p];
                    be_s2_q[p] <= be_s1_q[p];
                    wr_s1_q[p] <= write_select_n[p];
                    wr_s2_q[p] <= wr_s1_q[p];
                    csl_s1_q[p] <= chip_select_low_active_n[p];
                    csl_s2_q[p] <= csl_s1_q[p];
                    csh_s1_q[p] <= chip_select_high_active[p];
                    csh_s2_q[p] <= csh_s1_q[p];
                    oe_s1_q[p] <= output_enable_n[p];
                    oe_s2_q[p] <= oe_s1_q[p];
                    slow_s1_q[p] <= slow_clock_select[p];
                    slow_s2_q[p] <= slow_s1_q[p];
                end
            end

            // request decode from synchronised pins
            always_comb begin
                req_en_d[p] = !csl_s2_q[p] // [RULE2]
                    && csh_s2_q[p] // [RULE3]
                    && ready[p]; // [RULE11]
                req_we_d[p] = !wr_s2_q[p]; // [RULE1]
                req_be_d[p] = ~be_s2_q[p]; // [RULE4]
                req_a_d[p] = a_s2_q[p];
                req_wd_d[p] = d_s2_q[p];
            end

            // read lanes held until the port's next access
            always_comb begin
                rd_lane_d[p] = rd_lane_q[p];
                if (req_en_q[p]) begin
                    rd_lane_d[p] = req_we_q[p] ? '0 : req_be_q[p]; // [RULE4]
                end
            end

            // mailbox flag: set by other port's write, cleared by own read
            always_comb begin
                logic set, clr;
                set = req_en_q[1-p] && req_we_q[1-p]
                    && req_a_q[1-p] == dpr_mbox(1'(p)); // [RULE7] [RULE8]
                clr = req_en_q[p] && !req_we_q[p]
                    && req_a_q[p] == dpr_mbox(1'(p)); // [RULE9]
                mbox_d[p] = set || (mbox_q[p] && !clr);
            end

            // dll control and lock count
            always_comb begin
                dll_d[p] = dll_q[p];
                lock_d[p] = lock_q[p];
                dll_en_d[p] = !slow_s2_q[p]; // [RULE10]
                case (dll_q[p])
                    DPR_DLL_OFF: begin
                        if (!slow_s2_q[p]) begin
                            dll_d[p] = DPR_DLL_LOCKING;
                            lock_d[p] = '0;
                        end
                    end
                    DPR_DLL_LOCKING: begin
                        if (slow_s2_q[p]) begin
                            dll_d[p] = DPR_DLL_OFF; // [RULE10]
                        end else if (lock_q[p] ==
                                `DPR_CNT_W'(`DPR_LOCK_CYC - 1)) begin
                            dll_d[p] = DPR_DLL_LOCKED;
                        end else begin
                            lock_d[p] = lock_q[p] + `DPR_CNT_W'(1);
                        end
                    end
                    DPR_DLL_LOCKED: begin
                        if (slow_s2_q[p]) begin
                            dll_d[p] = DPR_DLL_OFF; // [RULE10]
                        end
                    end
                    default: begin
                        dll_d[p] = DPR_DLL_OFF;
                    end
                endcase
            end

            // port state registers
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    req_en_q[p] <= 1'b0;
                    req_we_q[p] <= 1'b0;
                    req_be_q[p] <= '0;
                    req_a_q[p] <= '0;
                    req_wd_q[p] <= '0;
                    rd_lane_q[p] <= '0;
                    mbox_q[p] <= 1'b0;
                    busy_q[p] <= 1'b0;
                    dll_q[p] <= DPR_DLL_OFF;
                    lock_q[p] <= '0;
                    dll_en_q[p] <= 1'b0;
                end else if (ce) begin
                    req_en_q[p] <= req_en_d[p]; // [RULE12]
                    req_we_q[p] <= req_we_d[p]; // [RULE12]
                    req_be_q[p] <= req_be_d[p];
                    req_a_q[p] <= req_a_d[p]; // [RULE12]
                    req_wd_q[p] <= req_wd_d[p]; // [RULE12]
                    rd_lane_q[p] <= rd_lane_d[p];
                    mbox_q[p] <= mbox_d[p];
                    busy_q[p] <= busy_d[p];
                    dll_q[p] <= dll_d[p];
                    lock_q[p] <= lock_d[p];
                    dll_en_q[p] <= dll_en_d[p];
                end
            end

            // array requests and pin outputs
            assign mbus.en[p] = req_en_q[p] && ce;
            assign mbus.we[p] = req_we_q[p]; // [RULE1]
            assign mbus.be[p] = req_be_q[p]; // [RULE4]
            assign mbus.addr[p] = req_a_q[p];
            assign mbus.wdata[p] = req_wd_q[p];
            assign dq_o[p] = mbus.rdata[p];
            assign dq_oe_n[p] = ~(dpr_expand(rd_lane_q[p])
                & {`DPR_DATA_W{!oe_s2_q[p]}}); // [RULE5] [RULE4]
            assign mailbox_flag_n[p] = !mbox_q[p]; // [RULE8] [RULE9]
            assign busy[p] = busy_q[p];
            assign ready[p] = dll_q[p] != DPR_DLL_LOCKING; // [RULE11]
            assign dll_enable[p] = dll_en_q[p]; // [RULE10]
        end
    endgenerate

    // collision: both ports on one word, at least one writing
    always_comb begin
        collide = req_en_q[0] && req_en_q[1]
            && req_a_q[0] == req_a_q[1]
            && (req_we_q[0] || req_we_q[1]); // [RULE6] [RULE13]
        busy_d = {collide, collide}; // [RULE6]
    end

    // shared array
    dpr_mem u_mem (
        .clk(clk),
        .ce(ce),
        .bus(mbus.mem)
    );
endmodule

// ==== tb/dpr_host.sv ====
// behavioural host controller driving one port's pins
`include "dpr_cfg.svh"
module dpr_host
    import dpr_pkg::*;
(
    // clock
    input wire logic clk,
    // pins toward the port
    output dpr_addr_t addr,
    output logic wr_n,
    output logic csl_n,
    output logic csh,
    output dpr_lanes_t be_n,
    output logic oe_n,
    output logic slow,
    output dpr_data_t dq
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: port deselected, output enable low, slow clock
    initial begin
        addr = '0;
        wr_n = 1'b1;
        csl_n = 1'b1;
        csh = 1'b0;
        be_n = '1;
        oe_n = 1'b0;
        slow = 1'b1;
        dq = '0;
    end
    // one access, sel is {csl_n, csh}, pins held for one cycle
    task automatic acc(input logic w, input dpr_addr_t a,
        input dpr_lanes_t b, input dpr_data_t d, input logic [1:0] sel);
        @(posedge clk);
        #1;
        wr_n = ~w;
        addr = a;
        be_n = b;
        {csl_n, csh} = sel;
        dq = w ? d : ~dq;
        @(posedge clk);
        #1;
        {csl_n, csh} = 2'b10;
        wr_n = 1'b1;
        dq = ~dq; // released bus shows no stale data
    endtask
endmodule

// ==== tb/dpr_top_props.sv ====
// assertions on the dual-port ram port pins, watched on port 0
`include "dpr_cfg.svh"
module dpr_top_props
    import dpr_pkg::*;
(
    // clock, enable, reset
    input wire logic clk,
    input wire logic ce,
    input wire logic sys_rst,
    // pins
    input wire logic [1:0][`DPR_ADDR_W-1:0] addr,
    input wire logic [1:0] write_select_n,
    input wire logic [1:0] chip_select_low_active_n,
    input wire logic [1:0] chip_select_high_active,
    input wire logic [1:0][`DPR_LANES-1:0] byte_lane_enable_n,
    input wire logic [1:0] output_enable_n,
    input wire logic [1:0] slow_clock_select,
    input wire logic [1:0][`DPR_DATA_W-1:0] dq_i,
    input wire logic [1:0][`DPR_DATA_W-1:0] dq_o,
    input wire logic [1:0][`DPR_DATA_W-1:0] dq_oe_n,
    input wire logic [1:0] busy,
    input wire logic [1:0] mailbox_flag_n,
    input wire logic [1:0] ready,
    input wire logic [1:0] dll_enable
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_rd;
        $changed(dq_o[0]) |-> $past(write_select_n[0], 4)
            && !$past(chip_select_low_active_n[0], 4)
            && $past(chip_select_high_active[0], 4);
    endproperty
    a_rd: assert property (p_rd) else $error("read data moved");
    property p_oe;
        $past(output_enable_n[0], 2) && $past(output_enable_n[0], 3)
            |-> dq_oe_n[0] == '1;
    endproperty
    a_oe: assert property (p_oe) else $error("pins driven");
    property p_set;
        $fell(mailbox_flag_n[0]) |-> !$past(write_select_n[1], 4)
            && $past(addr[1], 4) == `DPR_MBOX_P0;
    endproperty
    a_set: assert property (p_set) else $error("flag set");
    property p_clr;
        $rose(mailbox_flag_n[0]) |-> $past(write_select_n[0], 4)
            && $past(addr[0], 4) == `DPR_MBOX_P0;
    endproperty
    a_clr: assert property (p_clr) else $error("flag clear");
    property p_bsy;
        busy[0] |-> busy[1] && $past(addr[0], 4) == $past(addr[1], 4);
    endproperty
    a_bsy: assert property (p_bsy) else $error("busy cause");
    property p_slow;
        slow_clock_select[0] [*4] |=> !dll_enable[0] && ready[0];
    endproperty
    a_slow: assert property (p_slow) else $error("dll on");
    property p_lock;
        $fell(ready[0]) |-> !ready[0] [*8] ##1 !ready[0] [*8] ##1 ready[0];
    endproperty
    a_lock: assert property (p_lock) else $error("lock time");
    property p_nrdy;
        !ready[0] |-> dll_enable[0];
    endproperty
    a_nrdy: assert property (p_nrdy) else $error("not ready");
    c_bsy: cover property (busy[0]);
    c_flag: cover property ($fell(mailbox_flag_n[1]));
    c_lock: cover property ($rose(ready[0]));
endmodule

// ==== tb/dpr_top_tb.sv ====
// self-checking bench of the dual-port ram port logic
`include "dpr_cfg.svh"
module dpr_top_tb import dpr_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, sys_rst;
    logic ce = 1'b1;
    wire [1:0][`DPR_ADDR_W-1:0] addr;
    wire [1:0] write_select_n, chip_select_low_active_n;
    wire [1:0] chip_select_high_active, output_enable_n, slow_clock_select;
    wire [1:0][`DPR_LANES-1:0] byte_lane_enable_n;
    wire [1:0][`DPR_DATA_W-1:0] dq_i;
    logic [1:0][`DPR_DATA_W-1:0] dq_o, dq_oe_n;
    logic [1:0] busy, mailbox_flag_n, ready, dll_enable;
    int failures, checked;
    dpr_data_t d1 = {8{9'h0a5}};
    dpr_data_t d2 = {8{9'h15a}};
    dpr_top u_dut (.clk, .ce, .sys_rst, .addr, .write_select_n,
        .chip_select_low_active_n, .chip_select_high_active,
        .byte_lane_enable_n, .output_enable_n, .slow_clock_select, .dq_i,
        .dq_o, .dq_oe_n, .busy, .mailbox_flag_n, .ready, .dll_enable);
    // one host model per port
    for (genvar i = 0; i < 2; i++) begin : g_h
        dpr_host u_h (.clk, .addr(addr[i]), .wr_n(write_select_n[i]),
            .csl_n(chip_select_low_active_n[i]),
            .csh(chip_select_high_active[i]), .be_n(byte_lane_enable_n[i]),
            .oe_n(output_enable_n[i]), .slow(slow_clock_select[i]),
            .dq(dq_i[i]));
    end
    task automatic chk(input dpr_data_t got, input dpr_data_t exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic w3;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic t_rw;
        g_h[0].u_h.acc(1, 17'h5, '0, d1, 2'b01);
        g_h[0].u_h.acc(1, 17'h5, 8'hf0, d2, 2'b01);
        g_h[0].u_h.acc(1, 17'h5, '0, '0, 2'b11);
        g_h[0].u_h.acc(1, 17'h5, '0, '0, 2'b00);
        g_h[0].u_h.acc(0, 17'h5, '0, '0, 2'b01);
        w3;
        chk(dq_o[0], {d1[71:36], d2[35:0]});
        chk(dq_oe_n[0], '0);
        g_h[0].u_h.acc(0, 17'h5, 8'h0f, '0, 2'b01);
        w3;
        chk(dq_oe_n[0], {{36{1'b0}}, {36{1'b1}}});
        g_h[0].u_h.oe_n = 1'b1;
        g_h[0].u_h.acc(0, 17'h5, '0, '0, 2'b01);
        w3;
        chk(dq_oe_n[0], '1);
        g_h[0].u_h.oe_n = 1'b0;
        $display("test rw done");
    endtask
    task automatic t_mbox;
        g_h[1].u_h.acc(1, `DPR_MBOX_P0, '0, d1, 2'b01);
        w3;
        chk(mailbox_flag_n, 2'b10);
        g_h[0].u_h.acc(0, `DPR_MBOX_P0, '0, '0, 2'b01);
        w3;
        chk(dq_o[0], d1);
        chk(mailbox_flag_n, 2'b11);
        g_h[0].u_h.acc(1, `DPR_MBOX_P1, '0, d2, 2'b01);
        w3;
        chk(mailbox_flag_n, 2'b01);
        g_h[1].u_h.acc(0, `DPR_MBOX_P1, '0, '0, 2'b01);
        w3;
        chk(mailbox_flag_n, 2'b11);
        $display("test mailbox done");
    endtask
    // enable held low: a mailbox write must leave no trace
    task automatic t_ce;
        ce = 1'b0;
        g_h[1].u_h.acc(1, `DPR_MBOX_P0, '0, d2, 2'b01);
        w3;
        ce = 1'b1;
        w3;
        chk(mailbox_flag_n, 2'b11);
        $display("test enable done");
    endtask
    // one reads, one writes: no same-cycle double write
    task automatic t_busy;
        fork
            g_h[0].u_h.acc(0, 17'h9, '0, '0, 2'b01);
            g_h[1].u_h.acc(1, 17'h9, '0, d1, 2'b01);
        join
        w3;
        chk(busy, 2'b11);
        @(posedge clk);
        #1;
        chk(busy, 2'b00);
        $display("test busy done");
    endtask
    task automatic t_dll;
        int n;
        g_h[0].u_h.slow = 1'b0;
        for (n = 0; n < 40 && ready[0] !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        chk(dll_enable[0], 1'b1);
        n = 0;
        while (ready[0] === 1'b0 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, `DPR_LOCK_CYC);
        g_h[0].u_h.slow = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk({dll_enable[0], ready[0]}, 2'b01);
        $display("test dll done");
    endtask
    task automatic wrap_up;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // reset, then the tests
    initial begin
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        w3;
        t_rw;
        t_mbox;
        t_ce;
        t_busy;
        t_dll;
        wrap_up;
    end
    // watchdog
    initial begin
        repeat (2000) @(posedge clk);
        failures++;
        $display("BAD %0t timeout", $time);
        wrap_up;
    end
endmodule
bind dpr_top dpr_top_props u_props (.clk, .ce, .sys_rst, .addr,
    .write_select_n, .chip_select_low_active_n, .chip_select_high_active,
    .byte_lane_enable_n, .output_enable_n, .slow_clock_select, .dq_i,
    .dq_o, .dq_oe_n, .busy, .mailbox_flag_n, .ready, .dll_enable);
